// ---- common/flash_pkg.sv ----
package flash_pkg;
	// clock rates: sclk must also be slow enough to oversample
	localparam int SYS_MHZ       = 200;
	localparam int SCLK_MAX_MHZ  = 104;
	localparam int SCLK_MIN_HALF = (SYS_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
	// array geometry
	localparam int ADDR_BITS    = 24;
	localparam int PAGE_BYTES   = 256;
	localparam int SECTOR_BYTES = 4096;
	localparam int BLK32_BYTES  = 32768;
	localparam int BLK64_BYTES  = 65536;
	// timing of internal cycles, in sclk clocks or system clocks
	localparam int DUMMY_CLKS       = 8;
	localparam int STATUS_WR_CYCLES = 16;
	// status register layout
	localparam int         LOCK_POS    = 7;
	localparam int         BUSY_POS    = 0;
	localparam logic [7:0] STATUS_RST  = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// instruction codes
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_PROGRAM      = 8'h02;
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
	localparam logic [7:0] OP_DUAL_READ    = 8'h3b;
	localparam logic [7:0] OP_BLK32_ERASE  = 8'h52;
	localparam logic [7:0] OP_QUAD_READ    = 8'h6b;
	localparam logic [7:0] OP_CHIP_ERASE   = 8'hc7;
	localparam logic [7:0] OP_BLK64_ERASE  = 8'hd8;

	// shape of one instruction on the wire
	typedef struct packed {
		logic       known;
		logic       has_addr;
		logic       rd;
		logic [2:0] lanes;
		logic [3:0] dummy;
	} cmd_info_t;

	// decode used by both ends so they agree on framing
	function automatic cmd_info_t cmd_info(input logic [7:0] op);
		cmd_info_t c;
		c = '{1'b0, 1'b0, 1'b0, 3'h1, 4'h0};
		case (op)
			OP_READ:         c = '{1'b1, 1'b1, 1'b1, 3'h1, 4'h0};
			OP_DUAL_READ:    c = '{1'b1, 1'b1, 1'b1, 3'h2, 4'(DUMMY_CLKS)};
			OP_QUAD_READ:    c = '{1'b1, 1'b1, 1'b1, 3'h4, 4'(DUMMY_CLKS)};
			OP_STATUS_READ:  c = '{1'b1, 1'b0, 1'b1, 3'h1, 4'h0};
			OP_STATUS_WRITE: c = '{1'b1, 1'b0, 1'b0, 3'h1, 4'h0};
			OP_PROGRAM:      c = '{1'b1, 1'b1, 1'b0, 3'h1, 4'h0};
			OP_QUAD_PROGRAM: c = '{1'b1, 1'b1, 1'b0, 3'h4, 4'h0};
			OP_SECTOR_ERASE: c = '{1'b1, 1'b1, 1'b0, 3'h1, 4'h0};
			OP_BLK32_ERASE:  c = '{1'b1, 1'b1, 1'b0, 3'h1, 4'h0};
			OP_BLK64_ERASE:  c = '{1'b1, 1'b1, 1'b0, 3'h1, 4'h0};
			OP_CHIP_ERASE:   c = '{1'b1, 1'b0, 1'b0, 3'h1, 4'h0};
			default:         c = '{1'b0, 1'b0, 1'b0, 3'h1, 4'h0};
		endcase
		return c;
	endfunction : cmd_info
endpackage : flash_pkg

// ---- common/flash_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface flash_if;
	logic       cs_n;         // chip select, active low
	logic       sclk;         // serial clock from the host
	logic [3:0] host_io_out;  // host drive values
	logic [3:0] host_io_oe_n; // host enables, low drives
	logic [3:0] dev_io_out;   // device drive values
	logic [3:0] dev_io_oe_n;  // device enables, low drives
	logic [3:0] io_line;      // resolved level, pulled up when undriven

	// device wins a clash; an undriven line floats high through the pull-up
	assign io_line = (~dev_io_oe_n & dev_io_out) | (dev_io_oe_n & ~host_io_oe_n & host_io_out)
		| (dev_io_oe_n & host_io_oe_n);

	modport host (output cs_n, output sclk, output host_io_out, output host_io_oe_n, input io_line);
	modport dev (input cs_n, input sclk, input io_line, output dev_io_out, output dev_io_oe_n);
endinterface : flash_if
`default_nettype wire

// ---- rtl/sync2.sv ----
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r; // first stage, feeds only the second

	// two flops before any logic sees a pin
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_r <= RST_VAL;
			q_out  <= RST_VAL;
		end
		else
		begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule : sync2
`default_nettype wire

// ---- rtl/flash_dev.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - standard mode samples serial_in on rising sclk
// - standard mode drives output on falling sclk
// - dual/quad lines: in on rise, out on fall
// - chip select high tri-states all data lines
// - running internal cycle survives deselect
// - select low accepts instructions, returns data
// - no instruction before first select falling edge
// - pause low: tri-state output, ignore inputs
// - pause only outside quad; else io_line_3
// - wp low and lock set rejects status write
// - wp high ignores status_lock_bit
// - lines 0-1 dual/quad, 2-3 quad only
// - accepts clock mode 0 and mode 3
// - serial clock at most 104 MHz
// - page program writes 1 to 256 bytes
// - erase 4K sector, 32K or 64K block
// - whole array chip erase supported
// - host idles clock per chosen mode
// - program clears bits only; erase sets them
module flash_dev
	import flash_pkg::*;
#(
	parameter int MEM_AW = 22 // byte address width of the array
) (
	input  wire logic   clk_sys_in,
	input  wire logic   rst_in,
	flash_if.dev        bus,
	output logic        busy_out,
	output logic [7:0]  status_out
);
	localparam int WCW         = $clog2(STATUS_WR_CYCLES + 1);
	localparam int ARRAY_BYTES = 1 << MEM_AW;

	// an erase unit larger than a shrunken array clears all of it instead of wrapping to zero
	function automatic logic [MEM_AW:0] span_of(input int bytes);
		return (bytes >= ARRAY_BYTES) ? (MEM_AW + 1)'(ARRAY_BYTES) : (MEM_AW + 1)'(bytes);
	endfunction : span_of

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_CMD   = 3'h1,
		ST_ADDR  = 3'h3,
		ST_DUMMY = 3'h2,
		ST_DOUT  = 3'h6,
		ST_DIN   = 3'h7,
		ST_DONE  = 3'h5
	} dev_state_t;

	logic [7:0]  mem [0:(1 << MEM_AW) - 1]; // the array itself
	logic [5:0]  pins_s;       // synchronised pins
	logic        cs_n_s;       // select, synchronised
	logic        sclk_s;       // clock, synchronised
	logic [3:0]  io_s;         // data lines, synchronised
	logic        cs_d_r;       // select one cycle back
	logic        sclk_d_r;     // clock one cycle back
	logic        sess_r;       // inside an armed frame
	dev_state_t  state_r;      // frame progress
	logic [7:0]  op_r;         // current instruction
	cmd_info_t   info_r;       // its decode
	logic [4:0]  cnt_r;        // bits or clocks in phase
	logic [7:0]  sh_in_r;      // incoming shift
	logic [23:0] addr_r;       // current address
	logic        pend_r;       // erase waits for deselect
	logic [7:0]  status_r;     // status register
	logic [WCW-1:0] wr_cnt_r;  // status write cycle timer
	logic [MEM_AW-1:0] er_ptr_r;  // erase walk pointer
	logic [MEM_AW:0]   er_left_r; // bytes still to erase
	logic [7:0]  sh_out_r;     // outgoing shift
	logic [3:0]  ocnt_r;       // bits sent of this byte
	logic [3:0]  out_r;        // pin values
	logic        drive_r;      // first output edge seen

	logic        cs_fall, quad, paused, rise, fall, busy, byte_in, out_end, wr_allow, is_erase;
	logic [2:0]  w;
	logic [7:0]  sh_in_nxt, status_view, src_byte, cur_out;
	logic [4:0]  cnt_nxt;
	logic [3:0]  ocnt_nxt, lane_mask;
	cmd_info_t   new_info;
	dev_state_t  cmd_goto;
	logic [MEM_AW:0] er_span;

	// sync resets low so a select held low from power-up is never a fall
	sync2 #(.W(6), .RST_VAL(6'h00)) u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.d_in       ({bus.cs_n, bus.sclk, bus.io_line}),
		.q_out      (pins_s)
	);
	assign {cs_n_s, sclk_s, io_s} = pins_s;

	// frame qualifiers
	assign cs_fall  = cs_d_r & ~cs_n_s;
	assign quad     = info_r.lanes == 3'h4 && state_r != ST_CMD;
	assign paused   = sess_r & ~quad & ~io_s[3];
	// rising edge samples in either clock idle level
	assign rise     = sess_r & ~paused & sclk_s & ~sclk_d_r;
	assign fall     = sess_r & ~paused & ~sclk_s & sclk_d_r;
	assign busy     = (er_left_r != '0) | (wr_cnt_r != '0);
	assign status_view = {status_r[7:1], busy};
	assign wr_allow = io_s[2] | ~status_r[LOCK_POS];

	// lane count: instruction and address always single
	assign w = (state_r == ST_CMD || state_r == ST_ADDR) ? 3'h1 : info_r.lanes;
	assign lane_mask = (w == 3'h4) ? 4'hf : (w == 3'h2) ? 4'h3 : 4'h2;

	// incoming bits, highest lane carries the older bit
	always_comb
	begin
		case (w)
			3'h4:    sh_in_nxt = {sh_in_r[3:0], io_s};
			3'h2:    sh_in_nxt = {sh_in_r[5:0], io_s[1:0]};
			default: sh_in_nxt = {sh_in_r[6:0], io_s[0]};
		endcase
	end
	assign cnt_nxt  = cnt_r + 5'(w);
	assign byte_in  = rise && state_r == ST_DIN && cnt_nxt[2:0] == 3'h0;
	assign new_info = cmd_info(sh_in_nxt);

	// where a freshly decoded instruction goes; busy refuses all but status read
	always_comb
	begin
		if (!new_info.known || (busy && sh_in_nxt != OP_STATUS_READ))
			cmd_goto = ST_DONE;
		else if (new_info.has_addr)
			cmd_goto = ST_ADDR;
		else if (new_info.rd)
			cmd_goto = ST_DOUT;
		else if (sh_in_nxt == OP_STATUS_WRITE)
			cmd_goto = ST_DIN;
		else
			cmd_goto = ST_DONE;
	end

	assign is_erase = op_r == OP_SECTOR_ERASE || op_r == OP_BLK32_ERASE || op_r == OP_BLK64_ERASE;

	// outgoing byte: reload at each byte start
	assign src_byte = (op_r == OP_STATUS_READ) ? status_view : mem[addr_r[MEM_AW-1:0]];
	assign cur_out  = (ocnt_r == 4'h0) ? src_byte : sh_out_r;
	assign ocnt_nxt = ocnt_r + 4'(w);
	assign out_end  = fall && state_r == ST_DOUT && ocnt_nxt == 4'h8;

	// erase extent by instruction
	always_comb
	begin
		case (op_r)
			OP_SECTOR_ERASE: er_span = span_of(SECTOR_BYTES);
			OP_BLK32_ERASE:  er_span = span_of(BLK32_BYTES);
			OP_BLK64_ERASE:  er_span = span_of(BLK64_BYTES);
			default:         er_span = span_of(ARRAY_BYTES);
		endcase
	end

	// edge history and frame arming
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cs_d_r   <= 1'b0;
			sclk_d_r <= 1'b0;
			sess_r   <= 1'b0;
		end
		else
		begin
			cs_d_r   <= cs_n_s;
			sclk_d_r <= sclk_s;
			if (cs_n_s)
				sess_r <= 1'b0;
			else if (cs_fall)
				sess_r <= 1'b1;
		end
	end

	// instruction, address, dummy and data framing
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r <= ST_IDLE;
			op_r    <= 8'h00;
			info_r  <= '0;
			cnt_r   <= 5'h00;
			sh_in_r <= 8'h00;
			addr_r  <= 24'h00_0000;
		end
		else if (cs_fall)
		begin
			state_r <= ST_CMD;
			cnt_r   <= 5'h00;
			info_r  <= '0;
		end
		else if (cs_n_s)
			state_r <= ST_IDLE;
		else if (rise)
		begin
			case (state_r)
				ST_CMD:
				begin
					sh_in_r <= sh_in_nxt;
					cnt_r   <= cnt_nxt;
					if (cnt_nxt == 5'h08)
					begin
						op_r    <= sh_in_nxt;
						info_r  <= new_info;
						cnt_r   <= 5'h00;
						state_r <= cmd_goto;
					end
				end
				ST_ADDR:
				begin
					addr_r <= {addr_r[22:0], io_s[0]};
					cnt_r  <= cnt_nxt;
					if (cnt_nxt == 5'(ADDR_BITS))
					begin
						cnt_r <= 5'h00;
						if (info_r.dummy != 4'h0)
							state_r <= ST_DUMMY;
						else if (info_r.rd)
							state_r <= ST_DOUT;
						else if (is_erase)
							state_r <= ST_DONE;
						else
							state_r <= ST_DIN;
					end
				end
				ST_DUMMY:
				begin
					cnt_r <= 5'(cnt_r + 5'h01);
					if (5'(cnt_r + 5'h01) == {1'b0, info_r.dummy})
						state_r <= ST_DOUT;
				end
				ST_DIN:
				begin
					sh_in_r <= sh_in_nxt;
					cnt_r   <= byte_in ? 5'h00 : cnt_nxt;
					// address wraps inside the page, never past it
					if (byte_in && op_r != OP_STATUS_WRITE)
						addr_r[7:0] <= 8'(addr_r[7:0] + 8'h01);
				end
				default:
				begin
				end
			endcase
		end
		else if (out_end)
			addr_r <= 24'(addr_r + 24'h00_0001);
	end

	// erase request armed in frame, started at deselect
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			pend_r <= 1'b0;
		else if (cs_fall || (sess_r && cs_n_s))
			pend_r <= 1'b0;
		else if (rise && state_r == ST_CMD && cnt_nxt == 5'h08 && sh_in_nxt == OP_CHIP_ERASE && !busy)
			pend_r <= 1'b1;
		else if (rise && state_r == ST_ADDR && cnt_nxt == 5'(ADDR_BITS) && is_erase)
			pend_r <= 1'b1;
	end

	// erase walk runs one byte a cycle, whatever select does
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			er_ptr_r  <= '0;
			er_left_r <= '0;
		end
		else if (sess_r && cs_n_s && pend_r)
		begin
			er_ptr_r  <= addr_r[MEM_AW-1:0] & ~(MEM_AW'(er_span[MEM_AW-1:0] - 1'b1));
			er_left_r <= er_span;
		end
		else if (er_left_r != '0)
		begin
			er_ptr_r  <= MEM_AW'(er_ptr_r + 1'b1);
			er_left_r <= (MEM_AW + 1)'(er_left_r - 1'b1);
		end
	end

	// array writes: erase sets bits, program only clears them
	always_ff @(posedge clk_sys_in)
	begin
		if (er_left_r != '0)
			mem[er_ptr_r] <= ERASED_BYTE;
		else if (byte_in && op_r != OP_STATUS_WRITE)
			mem[addr_r[MEM_AW-1:0]] <= mem[addr_r[MEM_AW-1:0]] & sh_in_nxt;
	end

	// status register; a refused write leaves it and the timer alone
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status_r <= STATUS_RST;
			wr_cnt_r <= '0;
		end
		else if (byte_in && op_r == OP_STATUS_WRITE && wr_allow)
		begin
			status_r <= {sh_in_nxt[7:1], 1'b0};
			wr_cnt_r <= WCW'(STATUS_WR_CYCLES);
		end
		else if (wr_cnt_r != '0)
			wr_cnt_r <= WCW'(wr_cnt_r - 1'b1);
	end

	// read data leaves on falling edges
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sh_out_r <= 8'h00;
			ocnt_r   <= 4'h0;
			out_r    <= 4'h0;
			drive_r  <= 1'b0;
		end
		else if (cs_n_s || cs_fall)
		begin
			ocnt_r  <= 4'h0;
			drive_r <= 1'b0;
		end
		else if (fall && state_r == ST_DOUT)
		begin
			drive_r  <= 1'b1;
			sh_out_r <= cur_out << w;
			ocnt_r   <= out_end ? 4'h0 : ocnt_nxt;
			case (w)
				3'h4:    out_r <= cur_out[7:4];
				3'h2:    out_r <= {2'b00, cur_out[7:6]};
				default: out_r <= {2'b00, cur_out[7], 1'b0};
			endcase
		end
	end

	// lines float unless selected, unpaused and sending
	assign bus.dev_io_oe_n = (drive_r && state_r == ST_DOUT && !cs_n_s && !paused) ? ~lane_mask : 4'hf;
	assign bus.dev_io_out  = out_r;
	assign busy_out        = busy;
	assign status_out      = status_view;
endmodule : flash_dev
`default_nettype wire

// ---- rtl/flash_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_host
	import flash_pkg::*;
#(
	parameter int HALF_CYC = 8 // system clocks per sclk half
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	flash_if.host            bus,
	input  wire logic        start_in,
	input  wire logic [7:0]  op_in,
	input  wire logic [23:0] addr_in,
	input  wire logic [8:0]  len_in,
	input  wire logic        mode3_in,
	input  wire logic        wp_n_in,
	input  wire logic        pause_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wdata_valid_in,
	output logic             wdata_ready_out,
	output logic [7:0]       rdata_out,
	output logic             rdata_valid_out,
	output logic             busy_out,
	output logic             done_out
);
	// no faster than the limit; synchroniser margin rests on HALF_CYC alone
	localparam int HALF = (HALF_CYC < SCLK_MIN_HALF) ? SCLK_MIN_HALF : HALF_CYC;

	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_SETUP = 3'h1,
		H_LOW   = 3'h3,
		H_HIGH  = 3'h2,
		H_FETCH = 3'h6,
		H_END   = 3'h4
	} host_state_t;

	host_state_t st_r;      // sequencer
	logic [15:0] tim_r;     // half period timer
	logic        mode3_r;   // clock idles high
	cmd_info_t   info_r;    // decode of the frame
	logic [8:0]  len_r;     // data bytes
	logic [1:0]  ph_r;      // cmd, addr, dummy, data
	logic [11:0] pcnt_r;    // clocks left in phase
	logic [31:0] tx_r;      // instruction and address
	logic [7:0]  dat_r;     // write byte shift
	logic [7:0]  rx_r;      // read byte shift
	logic [3:0]  bpos_r;    // bits done in data byte
	logic [3:0]  out_r;     // pin values
	logic [3:0]  io_s;      // synchronised lines
	logic [11:0] clk_tab [4];
	logic [2:0]  nph;
	logic [3:0]  bpos_nxt;
	logic [7:0]  rx_nxt;
	logic        half_end, stall, quad, data_wr, rel;

	sync2 #(.W(4), .RST_VAL(4'hf)) u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.d_in       (bus.io_line),
		.q_out      (io_s)
	);

	assign quad     = info_r.lanes == 3'h4;
	assign stall    = pause_in & ~quad;
	assign half_end = tim_r == 16'(HALF - 1) && !stall;
	assign data_wr  = st_r != H_IDLE && ph_r == 2'h3 && !info_r.rd;
	// lanes the last frame let the device drive stay released while idle: the device lets go only after its select synchroniser
	assign rel      = st_r == H_IDLE || (ph_r[1] && info_r.rd);
	assign bpos_nxt = bpos_r + 4'(info_r.lanes);

	// clocks per phase, then the next phase that has any
	always_comb
	begin
		clk_tab[0] = 12'h008;
		clk_tab[1] = info_r.has_addr ? 12'(ADDR_BITS) : 12'h000;
		clk_tab[2] = 12'(info_r.dummy);
		clk_tab[3] = quad ? 12'({len_r, 1'b0}) : (info_r.lanes == 3'h2) ? 12'({len_r, 2'b00}) : {len_r, 3'b000};
		nph = 3'h4;
		for (int i = 3; i > 0; i--)
			if (i > ph_r && clk_tab[i] != 12'h000)
				nph = 3'(i);
	end

	always_comb
	begin
		case (info_r.lanes)
			3'h4:    rx_nxt = {rx_r[3:0], io_s};
			3'h2:    rx_nxt = {rx_r[5:0], io_s[1:0]};
			default: rx_nxt = {rx_r[6:0], io_s[1]};
		endcase
	end

	// clock sequencer: changes bits after falling edges, samples before them
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r    <= H_IDLE;
			tim_r   <= 16'h0000;
			mode3_r <= 1'b0;
			info_r  <= '0;
			len_r   <= 9'h000;
			ph_r    <= 2'h0;
			pcnt_r  <= 12'h000;
			bpos_r  <= 4'h0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			tim_r    <= (half_end || st_r == H_IDLE || st_r == H_FETCH) ? 16'h0000 : 16'(tim_r + (stall ? 16'h0000 : 16'h0001));
			case (st_r)
				H_IDLE:
				begin
					// idle level follows the mode input, so no clock edge lands on select
					mode3_r <= mode3_in;
					if (start_in)
					begin
						st_r    <= H_SETUP;
						info_r  <= cmd_info(op_in);
						len_r   <= len_in;
						ph_r    <= 2'h0;
						pcnt_r  <= 12'h008;
						bpos_r  <= 4'h0;
					end
				end
				// setup ends in a low half so the first bit is placed before the first rise
				H_SETUP:
					if (half_end)
						st_r <= H_LOW;
				H_LOW:
					if (half_end)
						st_r <= H_HIGH;
				H_HIGH:
					if (half_end)
					begin
						pcnt_r <= 12'(pcnt_r - 12'h001);
						if (ph_r == 2'h3)
							bpos_r <= (bpos_nxt == 4'h8) ? 4'h0 : bpos_nxt;
						if (pcnt_r == 12'h001 && nph == 3'h4)
							st_r <= H_END;
						else if (pcnt_r == 12'h001)
						begin
							ph_r   <= nph[1:0];
							pcnt_r <= clk_tab[nph[1:0]];
							st_r   <= (nph == 3'h3 && !info_r.rd) ? H_FETCH : H_LOW;
						end
						else
							st_r <= (data_wr && bpos_nxt == 4'h8) ? H_FETCH : H_LOW;
					end
				H_FETCH:
					if (wdata_valid_in)
						st_r <= H_LOW;
				H_END:
					if (half_end)
					begin
						st_r     <= H_IDLE;
						done_out <= 1'b1;
					end
				default:
					st_r <= H_IDLE;
			endcase
		end
	end

	// pin values; new bits are loaded at the end of the first cycle of each low half, on the pins from the second
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_r  <= 32'h0000_0000;
			dat_r <= 8'h00;
			out_r <= 4'hf;
		end
		else
		begin
			if (!(quad && data_wr))
				out_r[3:2] <= {~pause_in, wp_n_in};
			if (st_r == H_IDLE && start_in)
				tx_r <= {op_in, addr_in};
			else if (st_r == H_FETCH && wdata_valid_in)
				dat_r <= wdata_in;
			else if (st_r == H_LOW && tim_r == 16'h0000 && !stall && ph_r[1] == 1'b0)
			begin
				out_r[0] <= tx_r[31];
				tx_r     <= tx_r << 1;
			end
			else if (st_r == H_LOW && tim_r == 16'h0000 && !stall && data_wr)
			begin
				case (info_r.lanes)
					3'h4:    out_r <= dat_r[7:4];
					3'h2:    out_r[1:0] <= dat_r[7:6];
					default: out_r[0] <= dat_r[7];
				endcase
				dat_r <= dat_r << info_r.lanes;
			end
		end
	end

	// read bytes gathered at the end of each high half
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_r            <= 8'h00;
			rdata_out       <= 8'h00;
			rdata_valid_out <= 1'b0;
		end
		else
		begin
			rdata_valid_out <= 1'b0;
			if (st_r == H_HIGH && half_end && ph_r == 2'h3 && info_r.rd)
			begin
				rx_r <= rx_nxt;
				if (bpos_nxt == 4'h8)
				begin
					rdata_out       <= rx_nxt;
					rdata_valid_out <= 1'b1;
				end
			end
		end
	end

	// idle level of sclk follows the latched mode
	assign bus.sclk         = (st_r == H_HIGH) | (mode3_r & st_r != H_LOW & st_r != H_FETCH);
	assign bus.cs_n         = st_r == H_IDLE;
	assign bus.host_io_out  = out_r;
	assign bus.host_io_oe_n = {{2{quad & rel}}, ~(data_wr & info_r.lanes != 3'h1), rel & info_r.lanes != 3'h1};
	assign wdata_ready_out  = st_r == H_FETCH;
	assign busy_out         = st_r != H_IDLE;
endmodule : flash_host
`default_nettype wire

// ---- tb/flash_link_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_link_monitor (
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic [3:0] host_io_out,
	input wire logic [3:0] host_io_oe_n,
	input wire logic [3:0] dev_io_out,
	input wire logic [3:0] dev_io_oe_n
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// host holds the pause lane low while the device leaves it undriven
	sequence s_pause;
		(!cs_n && !host_io_oe_n[3] && !host_io_out[3] && dev_io_oe_n[3])[*6];
	endsequence
	// device turns on or moves its output lane
	sequence s_move;
		$fell(dev_io_oe_n[1]) || (!dev_io_oe_n[1] && $changed(dev_io_out));
	endsequence
	property p_desel;
		cs_n[*5] |-> dev_io_oe_n == 4'hf;
	endproperty
	property p_fall;
		s_move |-> !sclk;
	endproperty
	property p_pause;
		s_pause |-> dev_io_oe_n[1];
	endproperty
	property p_quad;
		!(dev_io_oe_n[2] && dev_io_oe_n[3]) |-> dev_io_oe_n == 4'h0;
	endproperty
	property p_dual;
		!dev_io_oe_n[0] |-> !dev_io_oe_n[1];
	endproperty
	// low lanes never fought over; upper lanes swap at quad turnaround
	property p_clash;
		(dev_io_oe_n[1:0] | host_io_oe_n[1:0]) == 2'h3;
	endproperty
	property p_setup;
		$fell(cs_n) |-> $stable(sclk)[*4];
	endproperty
	property p_rate;
		$changed(sclk) |=> $stable(sclk)[*4];
	endproperty
	a_desel: assert property (p_desel) else $error("drive while deselected");
	a_fall: assert property (p_fall) else $error("output moved on high clock");
	a_pause: assert property (p_pause) else $error("output kept in pause");
	a_quad: assert property (p_quad) else $error("upper lanes outside quad");
	a_dual: assert property (p_dual) else $error("lane 0 without lane 1");
	a_clash: assert property (p_clash) else $error("lane driven twice");
	a_setup: assert property (p_setup) else $error("clock edge at select");
	a_rate: assert property (p_rate) else $error("clock half too short");
endmodule : flash_link_monitor
`default_nettype wire

// ---- tb/tb_serial_flash_pin_interface.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_serial_flash_pin_interface
	import flash_pkg::*;
;
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        start = 1'b0, mode3 = 1'b0, wp_n = 1'b1, pause = 1'b0;
	logic [7:0]  op = 8'h00, wd = 8'h00, rd, st, stat, mem[4096];
	logic [7:0]  wq[$] = {8'h00}, rq[$];
	logic [23:0] addr = 24'h00_0000, a;
	logic [8:0]  len = 9'h000;
	logic        rdy, rv, done, dbusy, ok;
	logic [7:0]  rops[3] = '{OP_READ, OP_DUAL_READ, OP_QUAD_READ};
	logic [7:0]  eops[3] = '{OP_SECTOR_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE};
	int          n_mismatch = 0, samples_checked = 0, seed = 32'hd3b1;
	flash_if flash_if_inst ();
	flash_host #(.HALF_CYC(8)) flash_host_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.bus(flash_if_inst.host), .start_in(start), .op_in(op), .addr_in(addr), .len_in(len),
		.mode3_in(mode3), .wp_n_in(wp_n), .pause_in(pause), .wdata_in(wd), .wdata_valid_in(1'b1),
		.wdata_ready_out(rdy), .rdata_out(rd), .rdata_valid_out(rv), .busy_out(), .done_out(done));
	// small array keeps the erase walks short
	flash_dev #(.MEM_AW(12)) flash_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.bus(flash_if_inst.dev), .busy_out(dbusy), .status_out(st));
	flash_link_monitor flash_link_monitor_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cs_n(flash_if_inst.cs_n), .sclk(flash_if_inst.sclk),
		.host_io_out(flash_if_inst.host_io_out), .host_io_oe_n(flash_if_inst.host_io_oe_n),
		.dev_io_out(flash_if_inst.dev_io_out), .dev_io_oe_n(flash_if_inst.dev_io_oe_n));
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic wr_ok(input logic w, input logic lock);
		return w | !lock;
	endfunction : wr_ok
	// one transfer; ready is sampled at the edge that takes the byte
	task automatic frame(input logic [7:0] o, input logic [23:0] ad, input int n);
		int k;
		k = 0;
		rq = {};
		op <= o;
		addr <= ad;
		len <= 9'(n);
		wd <= wq[0];
		start <= 1'b1;
		@(posedge clk_sys_in);
		start <= 1'b0;
		do
		begin
			@(posedge clk_sys_in);
			if (rv)
				rq.push_back(rd);
			if (rdy && k < n - 1)
			begin
				k++;
				wd <= wq[k];
			end
		end while (!done);
	endtask : frame
	// program model: bits only clear, address wraps in the page
	task automatic prog(input logic [7:0] o, input logic [23:0] ad, input int n);
		logic [11:0] ix;
		wq = {};
		for (int i = 0; i < n; i++)
		begin
			wq.push_back(8'($random(seed)));
			ix = {ad[11:8], 8'(ad[7:0] + 8'(i))};
			mem[ix] = mem[ix] & wq[i];
		end
		frame(o, ad, n);
	endtask : prog
	task automatic rdchk(input logic [7:0] o, input logic [23:0] ad, input int n, input bit p);
		fork
			frame(o, ad, n);
			if (p)
			begin
				repeat (700) @(posedge clk_sys_in);
				pause <= 1'b1;
				repeat (40) @(posedge clk_sys_in);
				pause <= 1'b0;
			end
		join
		for (int i = 0; i < n; i++)
			chk("rdata", mem[12'(ad + 24'(i))], rq[i]);
	endtask : rdchk
	// any erase covers the whole 4K array here
	task automatic er(input logic [7:0] o, input logic [23:0] ad);
		frame(o, ad, 0);
		repeat (5) @(posedge clk_sys_in);
		chk("busy", 8'h01, {7'h00, dbusy});
		while (dbusy)
			@(posedge clk_sys_in);
		foreach (mem[i])
			mem[i] = ERASED_BYTE;
	endtask : er
	task automatic sw(input logic w, input logic [7:0] v);
		ok = wr_ok(w, stat[LOCK_POS]);
		wp_n <= w;
		wq = {v};
		frame(OP_STATUS_WRITE, 24'h00_0000, 1);
		@(posedge clk_sys_in);
		if (!ok)
			chk("busy", 8'h00, {7'h00, dbusy});
		while (dbusy)
			@(posedge clk_sys_in);
		if (ok)
			stat = {v[7:1], 1'b0};
		frame(OP_STATUS_READ, 24'h00_0000, 1);
		chk("status", stat, rq[0]);
	endtask : sw
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		stat = STATUS_RST;
		repeat (10) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		er(OP_CHIP_ERASE, 24'h00_0000);
		for (int m = 0; m < 2; m++)
		begin
			mode3 <= m[0];
			repeat (20) @(posedge clk_sys_in);
			a = 24'({$random(seed)} & 32'h0000_0ff0);
			prog(OP_QUAD_PROGRAM, a, 16);
			prog(OP_PROGRAM, a, 1);
			for (int r = 0; r < 3; r++)
				rdchk(rops[r], a, 16, r == 0);
			$display("test mode %0d done", m);
		end
		for (int e = 0; e < 3; e++)
		begin
			prog(OP_QUAD_PROGRAM, a, 16);
			er(eops[e], a);
			rdchk(OP_READ, a, 4, 1'b0);
		end
		$display("test erase done");
		sw(1'b1, 8'h80);
		sw(1'b0, 8'h00);
		sw(1'b1, 8'h00);
		sw(1'b0, 8'h0c);
		$display("test status done");
		final_report();
	end
	// hang guard, well beyond the longest erase walk
	initial
	begin
		repeat (80000) @(posedge clk_sys_in);
		n_mismatch++;
		final_report();
	end
endmodule : tb_serial_flash_pin_interface
`default_nettype wire
